// ---- core/sdb_cfg.svh ----
// Purpose: offsets, field positions, reset values and counts
// Assumes: APB byte addressing, one register per aligned word
// Notes: definitions only
`ifndef SDB_CFG_SVH
`define SDB_CFG_SVH
// -----------------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------------
`define SDB_OFF_STAT1 8'h00
`define SDB_OFF_BAUD 8'h04
`define SDB_OFF_IRC 8'h08
`define SDB_OFF_IST 8'h0C
`define SDB_OFF_IMSK 8'h10
`define SDB_OFF_DATA 8'h18
// -----------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------
`define SDB_ST_TE 7
`define SDB_ST_TC 6
`define SDB_ST_RF 5
`define SDB_ST_FE 1
`define SDB_IRQ_TE 0
`define SDB_IRQ_RF 1
`define SDB_IRQ_FE 2
// -----------------------------------------------------------------------
// reset values and counts
// -----------------------------------------------------------------------
`define SDB_RST_BAUD 6'h00
`define SDB_RST_IRC 3'h0
`define SDB_RST_MASK 3'h0
`define SDB_PD_0 11'h001
`define SDB_PD_1 11'h003
`define SDB_PD_2 11'h004
`define SDB_PD_3 11'h00D
`define SDB_RT_LAST 4'hF
`define SDB_RT_MID 4'h7
`define SDB_LAST_BIT 4'h8
`define SDB_TX_LAST_BIT 4'h9
`define SDB_IRW_316 2'h0
`define SDB_IRW_132 2'h3
`define SDB_IRLEN_316 4'h3
`define SDB_IRLEN_116 4'h1
`endif

// ---- core/sdb_pkg.sv ----
// Purpose: shared types of the serial data, baud and infrared block
// Assumes: constants live in sdb_cfg.svh
// Notes: configuration travels as packed structs
`default_nettype none
package sdb_pkg;
    // baud generator settings
    typedef struct packed {
        logic src_bus;
        logic [1:0] pcode;
        logic [2:0] rcode;
    } sdb_baud_cfg_t;
    // infrared settings
    typedef struct packed {
        logic enable;
        logic [1:0] width;
    } sdb_ir_cfg_t;
    typedef enum logic {SDB_TX_IDLE, SDB_TX_SEND} sdb_tx_state_t;
    typedef enum logic [1:0] {SDB_RX_IDLE, SDB_RX_START, SDB_RX_DATA}
        sdb_rx_state_t;
endpackage
`default_nettype wire

// ---- core/sdb_baud.sv ----
// Purpose: prescaler and power-of-two divider, 16x sample tick
// Assumes: src_en is a one-cycle enable at the source clock rate
// Notes: half_tick marks the middle of each sample period
`include "sdb_cfg.svh"
`default_nettype none
module sdb_baud
    import sdb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic src_en,
    input wire sdb_baud_cfg_t cfg,
    output logic rt_tick,
    output logic half_tick
);
    logic [10:0] pd;
    logic [10:0] div_m1;
    logic [10:0] cnt;
    // prescaler divisor times power-of-two divisor, minus one
    assign pd = (cfg.pcode == 2'h0) ? `SDB_PD_0 :
                (cfg.pcode == 2'h1) ? `SDB_PD_1 :
                (cfg.pcode == 2'h2) ? `SDB_PD_2 : `SDB_PD_3;
    assign div_m1 = 11'((pd << cfg.rcode) - 11'h001);
    // >= so a smaller divisor written mid-count cannot overrun
    assign rt_tick = src_en & (cnt >= div_m1);
    assign half_tick = src_en & (cnt == (div_m1 >> 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 11'h000;
        end else if (rt_tick) begin
            cnt <= 11'h000;
        end else if (src_en) begin
            cnt <= cnt + 11'h001;
        end
    end
endmodule
`default_nettype wire

// ---- core/sdb_ir.sv ----
// Purpose: infrared narrow-pulse encoder and pulse-stretch decoder
// Assumes: line idles high, a zero bit is a low pulse
// Notes: the 1/32 width ends at the middle of the first sample period
`include "sdb_cfg.svh"
`default_nettype none
module sdb_ir
    import sdb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire sdb_ir_cfg_t cfg,
    input wire logic rt_tick,
    input wire logic half_tick,
    input wire logic [3:0] tx_phase,
    input wire logic tx_bit,
    input wire logic rx_pin,
    output logic ir_tx,
    output logic rx_dec
);
    logic first_half;
    logic zero_pulse;
    logic [3:0] len;
    logic [3:0] hold;
    // code 10 treated as 1/16 wide
    assign len = (cfg.width == `SDB_IRW_316) ? `SDB_IRLEN_316
                                             : `SDB_IRLEN_116;
    assign zero_pulse = ~tx_bit & ((cfg.width == `SDB_IRW_132)
        ? (tx_phase == 4'h0) & first_half : (tx_phase < len));
    // encoder and decoder flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_half <= 1'b0;
            ir_tx <= 1'b1;
            hold <= 4'h0;
            rx_dec <= 1'b1;
        end else begin
            first_half <= rt_tick | (first_half & ~half_tick);
            ir_tx <= ~(cfg.enable & zero_pulse);
            if (!rx_pin && hold == 4'h0) begin
                hold <= `SDB_RT_LAST;
            end else if (rt_tick && hold != 4'h0) begin
                hold <= hold - 4'h1;
            end
            rx_dec <= rx_pin & (hold == 4'h0);
        end
    end
endmodule
`default_nettype wire

// ---- core/sdb_top.sv ----
// Purpose: data buffer, baud generator and infrared control over APB
// Assumes: 8N1 frames, transmitter and receiver always enabled
// Notes: two-cycle APB access, PREADY from a flop
//
// Design decision made here: the APB slave port.
`include "sdb_cfg.svh"
`default_nettype none
module sdb_top
    import sdb_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic OSC_CLK,
    input wire logic RXD,
    output logic TXD,
    output logic IRQ
);
    // -------------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------------
    logic acc_first, acc_done, mapped, wr_done, rd_done;
    logic hit_stat, hit_baud, hit_irc, hit_ist, hit_imsk, hit_data;
    logic [31:0] rd_word;

    // first access cycle prepares data, second completes
    assign acc_first = PSEL & PENABLE & ~PREADY;
    assign acc_done = PSEL & PENABLE & PREADY;
    assign hit_stat = (PADDR == `SDB_OFF_STAT1);
    assign hit_baud = (PADDR == `SDB_OFF_BAUD);
    assign hit_irc = (PADDR == `SDB_OFF_IRC);
    assign hit_ist = (PADDR == `SDB_OFF_IST);
    assign hit_imsk = (PADDR == `SDB_OFF_IMSK);
    assign hit_data = (PADDR == `SDB_OFF_DATA);
    assign mapped = hit_stat | hit_baud | hit_irc | hit_ist | hit_imsk |
                    hit_data;
    assign wr_done = acc_done & PWRITE & mapped;
    assign rd_done = acc_done & ~PWRITE & mapped;

    // -------------------------------------------------------------------
    // control registers
    // -------------------------------------------------------------------
    sdb_baud_cfg_t baud_rate_select;
    sdb_ir_cfg_t infrared_control;
    logic [2:0] irq_mask;

    // writes take effect only on the completing edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            baud_rate_select <= `SDB_RST_BAUD;
            infrared_control <= `SDB_RST_IRC;
            irq_mask <= `SDB_RST_MASK;
        end else if (wr_done) begin
            if (hit_baud) begin
                baud_rate_select <= PWDATA[5:0];
            end
            if (hit_irc) begin
                infrared_control <= PWDATA[2:0];
            end
            if (hit_imsk) begin
                irq_mask <= PWDATA[2:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // pin synchronisers and source clock edge
    // -------------------------------------------------------------------
    logic osc_s1, osc_s2, osc_s3, src_en;
    logic rxd_s1, rxd_s2;

    // two flops before any logic reads a pin
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
        end else begin
            osc_s1 <= OSC_CLK;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            rxd_s1 <= RXD;
            rxd_s2 <= rxd_s1;
        end
    end

    // oscillator must run below half of CLK to be seen
    assign src_en = baud_rate_select.src_bus | (osc_s2 & ~osc_s3);

    // -------------------------------------------------------------------
    // baud generator, shared by both directions
    // -------------------------------------------------------------------
    logic rt_tick;
    logic half_tick;

    sdb_baud u_baud (
        .clk(CLK),
        .rst_n(RST_N),
        .src_en(src_en),
        .cfg(baud_rate_select),
        .rt_tick(rt_tick),
        .half_tick(half_tick)
    );

    // -------------------------------------------------------------------
    // transmit side
    // -------------------------------------------------------------------
    logic [7:0] transmit_bits;
    logic transmitter_empty_flag, te_arm, tx_load, tx_bit, next_te;
    logic [9:0] tx_shift;
    logic [3:0] tx_phase, tx_count;
    sdb_tx_state_t tx_state;

    // buffer holds its value through reset
    always_ff @(posedge CLK) begin
        if (wr_done && hit_data) begin
            transmit_bits <= PWDATA[7:0];
        end
    end

    // moves on a sample tick so the start bit keeps its full length
    assign tx_load = ~transmitter_empty_flag & (tx_state == SDB_TX_IDLE) &
                     rt_tick;
    // the transfer sets the flag even in a clearing cycle
    assign next_te = tx_load | (transmitter_empty_flag &
                     ~(wr_done & hit_data & te_arm));

    // empty flag and its clearing sequence
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            transmitter_empty_flag <= 1'b1;
            te_arm <= 1'b0;
        end else begin
            transmitter_empty_flag <= next_te;
            if (wr_done && hit_data) begin
                te_arm <= 1'b0;
            end else if (rd_done && hit_stat && transmitter_empty_flag) begin
                te_arm <= 1'b1;
            end
        end
    end

    // transmit shifter, start bit first, lsb next
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_state <= SDB_TX_IDLE;
            tx_shift <= 10'h3FF;
            tx_phase <= 4'h0;
            tx_count <= 4'h0;
        end else begin
            case (tx_state)
                SDB_TX_IDLE: begin
                    if (tx_load) begin
                        tx_shift <= {1'b1, transmit_bits, 1'b0};
                        tx_phase <= 4'h0;
                        tx_count <= 4'h0;
                        tx_state <= SDB_TX_SEND;
                    end
                end
                SDB_TX_SEND: begin
                    if (rt_tick) begin
                        tx_phase <= tx_phase + 4'h1;
                        if (tx_phase == `SDB_RT_LAST) begin
                            tx_shift <= {1'b1, tx_shift[9:1]};
                            tx_count <= tx_count + 4'h1;
                            if (tx_count == `SDB_TX_LAST_BIT) begin
                                tx_state <= SDB_TX_IDLE;
                            end
                        end
                    end
                end
                default: tx_state <= SDB_TX_IDLE;
            endcase
        end
    end

    assign tx_bit = (tx_state == SDB_TX_SEND) ? tx_shift[0] : 1'b1;

    // -------------------------------------------------------------------
    // infrared encoder and decoder
    // -------------------------------------------------------------------
    logic ir_tx;
    logic rx_dec;
    logic line_in;

    sdb_ir u_ir (
        .clk(CLK),
        .rst_n(RST_N),
        .cfg(infrared_control),
        .rt_tick(rt_tick),
        .half_tick(half_tick),
        .tx_phase(tx_phase),
        .tx_bit(tx_bit),
        .rx_pin(rxd_s2),
        .ir_tx(ir_tx),
        .rx_dec(rx_dec)
    );

    // data stream takes the infrared path only when enabled
    assign line_in = infrared_control.enable ? rx_dec : rxd_s2;

    // -------------------------------------------------------------------
    // receive side
    // -------------------------------------------------------------------
    logic [7:0] received_bits;
    logic [8:0] rx_shift;
    logic [3:0] rx_phase, rx_count;
    logic rx_done, receiver_full_flag, rx_frame_err, rf_arm, rf_clear;
    logic fe_set, rx_store;
    sdb_rx_state_t rx_state;

    // start bit confirmed mid-bit, then one sample per bit time
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_state <= SDB_RX_IDLE;
            rx_shift <= 9'h000;
            rx_phase <= 4'h0;
            rx_count <= 4'h0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            case (rx_state)
                SDB_RX_IDLE: begin
                    if (rt_tick && !line_in) begin
                        rx_phase <= 4'h0;
                        rx_state <= SDB_RX_START;
                    end
                end
                SDB_RX_START: begin
                    if (rt_tick) begin
                        rx_phase <= rx_phase + 4'h1;
                        if (rx_phase == `SDB_RT_MID) begin
                            rx_phase <= 4'h0;
                            rx_count <= 4'h0;
                            // a high level here was only a glitch
                            rx_state <= line_in ? SDB_RX_IDLE : SDB_RX_DATA;
                        end
                    end
                end
                SDB_RX_DATA: begin
                    if (rt_tick) begin
                        rx_phase <= rx_phase + 4'h1;
                        if (rx_phase == `SDB_RT_LAST) begin
                            rx_shift <= {line_in, rx_shift[8:1]};
                            rx_count <= rx_count + 4'h1;
                            if (rx_count == `SDB_LAST_BIT) begin
                                rx_done <= 1'b1;
                                rx_state <= SDB_RX_IDLE;
                            end
                        end
                    end
                end
                default: rx_state <= SDB_RX_IDLE;
            endcase
        end
    end

    // a frame arriving while full is dropped unless the flag clears now
    always_ff @(posedge CLK) begin
        if (rx_store) begin
            received_bits <= rx_shift[7:0];
        end
    end

    assign rf_clear = rd_done & hit_data & rf_arm;
    // a byte landing on the clearing edge is kept: the set wins
    assign rx_store = rx_done & (~receiver_full_flag | rf_clear);
    assign fe_set = rx_store & ~rx_shift[8];

    // full and framing flags, a new frame wins over the clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            receiver_full_flag <= 1'b0;
            rx_frame_err <= 1'b0;
            rf_arm <= 1'b0;
        end else begin
            receiver_full_flag <= rx_store | (receiver_full_flag & ~rf_clear);
            rx_frame_err <= fe_set | (rx_frame_err & ~rf_clear);
            if (rd_done && hit_data) begin
                rf_arm <= 1'b0;
            end else if (rd_done && hit_stat && receiver_full_flag) begin
                rf_arm <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // interrupt status and mask
    // -------------------------------------------------------------------
    logic [2:0] irq_status, irq_event, irq_w1c, next_irq_status;

    assign irq_event = {fe_set, rx_store, tx_load};
    assign irq_w1c = (wr_done && hit_ist) ? PWDATA[2:0] : 3'h0;
    // events win over a write-one clear in the same cycle
    assign next_irq_status = irq_event | (irq_status & ~irq_w1c);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // -------------------------------------------------------------------
    // read mux and registered outputs
    // -------------------------------------------------------------------
    logic [7:0] stat1_word;

    assign stat1_word = {transmitter_empty_flag,
                         transmitter_empty_flag & (tx_state == SDB_TX_IDLE),
                         receiver_full_flag, 3'h0, rx_frame_err, 1'b0};
    // read side of the data address is the received byte only
    assign rd_word = hit_stat ? {24'h000000, stat1_word} :
                     hit_baud ? {26'h0, baud_rate_select} :
                     hit_irc ? {29'h0, infrared_control} :
                     hit_ist ? {29'h0, irq_status} :
                     hit_imsk ? {29'h0, irq_mask} :
                     hit_data ? {24'h000000, received_bits} :
                     32'h00000000;

    // one wait state: data and ready settle in the first access cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= acc_first;
            PSLVERR <= acc_first & ~mapped;
            if (acc_first && !PWRITE) begin
                PRDATA <= rd_word;
            end
        end
    end

    // line and interrupt pins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TXD <= 1'b1;
            IRQ <= 1'b0;
        end else begin
            TXD <= infrared_control.enable ? ir_tx : tx_bit;
            IRQ <= |(irq_status & irq_mask);
        end
    end
endmodule
`default_nettype wire

// ---- testbench/sdb_top_asserts.sv ----
// Purpose: bus, interrupt and line checks on the top ports
// Assumes: offsets from sdb_cfg.svh
// Notes: bound to every sdb_top instance
`include "sdb_cfg.svh"
`default_nettype none
module sdb_top_asserts (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic OSC_CLK,
    input wire logic RXD,
    input wire logic TXD,
    input wire logic IRQ
);
    // ----------------
    // decode and steps
    // ----------------
    wire logic mapped;
    wire logic rd_done;
    assign mapped = PADDR inside {`SDB_OFF_STAT1, `SDB_OFF_BAUD,
        `SDB_OFF_IRC, `SDB_OFF_IST, `SDB_OFF_IMSK, `SDB_OFF_DATA};
    assign rd_done = PREADY && !PWRITE;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PSEL && PENABLE;
    endsequence
    // ----------------
    // checks
    // ----------------
    chk_ready_wait: assert property (
        s_setup ##1 s_access |=> PREADY) else $error("ready late");
    chk_ready_pulse: assert property (
        PREADY |=> !PREADY) else $error("ready too long");
    chk_ready_access: assert property (
        PREADY |-> s_access) else $error("ready outside access");
    chk_err_map: assert property (
        PREADY |-> PSLVERR == !mapped) else $error("error flag wrong");
    chk_err_ready: assert property (
        PSLVERR |-> PREADY) else $error("error without ready");
    chk_read_hole: assert property (
        rd_done && !mapped |-> PRDATA == 32'h0) else $error("hole not 0");
    chk_read_width: assert property (
        rd_done |-> PRDATA[31:8] == 24'h0) else $error("upper bits set");
    chk_rdata_hold: assert property (
        !rd_done |-> $stable(PRDATA)) else $error("read data moved");
    chk_irq_masked: assert property (
        PREADY && PWRITE && PADDR == `SDB_OFF_IMSK && PWDATA[2:0] == 3'h0
        |-> ##2 !IRQ) else $error("masked irq high");
    chk_reset_idle: assert property (
        $rose(RST_N) |-> TXD && !IRQ && !PREADY) else $error("not idle");
endmodule
bind sdb_top sdb_top_asserts i_chk (.CLK, .RST_N, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .OSC_CLK,
    .RXD, .TXD, .IRQ);
`default_nettype wire

// ---- testbench/sdb_line_model.sv ----
// Purpose: remote transceiver that sends frames into the receive pin
// Assumes: 8N1, lsb first, line idles high
// Notes: bit time is given in bus clock cycles
`default_nettype none
module sdb_line_model (
    input wire logic clk,
    output var logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rxd = 1'b1;
    // infrared zero is a 3-cycle low pulse, the rest of the bit stays high
    task automatic send_byte(input logic [7:0] b, input int cyc,
        input logic ir);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            for (int c = 0; c < cyc; c++) begin
                rxd <= f[i] | (ir && c >= 3);
                @(posedge clk);
            end
        end
        rxd <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- testbench/sci_data_baud_infrared_test.sv ----
// Purpose: self-checking bench for the data, baud and infrared block
// Assumes: bus source at divisor 1 gives 16 cycles per bit
// Notes: the oscillator pin runs at a quarter of the bus clock
`include "sdb_cfg.svh"
`default_nettype none
module sci_data_baud_infrared_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA, q;
    logic PREADY, PSLVERR, TXD, IRQ, RXD, e;
    logic OSC_CLK = 1'b0;
    logic [1:0] osc_cnt = 2'h0;
    int mismatches = 0, checked = 0, cycles = 0, len, lows;
    int pd [4] = '{1, 3, 4, 13};
    always #50 CLK = ~CLK;
    // slow source clock and run limit
    always @(posedge CLK) begin
        osc_cnt <= osc_cnt + 2'h1;
        OSC_CLK <= osc_cnt[1];
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            mismatches++;
            complete_run;
        end
    end
    sdb_top i_dut (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .OSC_CLK, .RXD, .TXD, .IRQ);
    sdb_line_model i_far (.clk(CLK), .rxd(RXD));
    // ----------------
    // bus tasks
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // idle cycle at the end so the next setup never overlaps a release
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 20) mismatches++;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // status read first so the data write really clears the empty flag
    task automatic send(input logic [31:0] d);
        xfer(1'b0, `SDB_OFF_STAT1, 32'h0);
        xfer(1'b1, `SDB_OFF_DATA, d);
    endtask
    // byte 01: lsb is high, so the first low run is the start bit alone
    task automatic tx_len(input int exp);
        int n;
        n = 0;
        len = 0;
        send(32'h01);
        while (TXD !== 1'b0 && n < 3000) begin
            @(posedge CLK);
            n++;
        end
        while (TXD === 1'b0 && len < 3000) begin
            @(posedge CLK);
            len++;
        end
        chk(len, exp);
        repeat (10 * exp) @(posedge CLK);
    endtask
    // byte 55 has five zero bits with the start bit
    task automatic ir_low(input logic [1:0] code, input int exp);
        xfer(1'b1, `SDB_OFF_IRC, {29'h0, 1'b1, code});
        send(32'h55);
        lows = 0;
        repeat (400) begin
            @(posedge CLK);
            lows += (TXD === 1'b0);
        end
        chk(lows, 5 * exp);
    endtask
    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------
    // main sequence
    // ----------------
    initial begin
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        rd(`SDB_OFF_STAT1, 32'hC0);
        rd(`SDB_OFF_BAUD, 32'h0);
        rd(`SDB_OFF_IRC, 32'h0);
        rd(`SDB_OFF_IMSK, 32'h0);
        rd(8'h14, 32'h0);
        chk(e, 32'h1);
        xfer(1'b1, `SDB_OFF_BAUD, 32'h3F);
        rd(`SDB_OFF_BAUD, 32'h3F);
        xfer(1'b1, `SDB_OFF_IRC, 32'h7);
        rd(`SDB_OFF_IRC, 32'h7);
        xfer(1'b1, `SDB_OFF_IRC, 32'h0);
        xfer(1'b1, `SDB_OFF_BAUD, 32'h0);
        tx_len(64);
        for (int r = 0; r < 8; r++) begin
            xfer(1'b1, `SDB_OFF_BAUD, 32'h20 | 32'(r));
            tx_len(16 << r);
        end
        for (int p = 1; p < 4; p++) begin
            xfer(1'b1, `SDB_OFF_BAUD, 32'h20 | 32'(p << 3));
            tx_len(16 * pd[p]);
        end
        // receive at the rate the transmitter used
        xfer(1'b1, `SDB_OFF_BAUD, 32'h20);
        i_far.send_byte(8'hC3, 16, 1'b0);
        repeat (16) @(posedge CLK);
        rd(`SDB_OFF_STAT1, 32'hE0);
        rd(`SDB_OFF_DATA, 32'hC3);
        rd(`SDB_OFF_STAT1, 32'hC0);
        xfer(1'b1, `SDB_OFF_DATA, 32'h5A);
        rd(`SDB_OFF_DATA, 32'hC3);
        repeat (200) @(posedge CLK);
        // interrupt masked, then unmasked, then cleared
        xfer(1'b1, `SDB_OFF_IST, 32'h7);
        xfer(1'b1, `SDB_OFF_IMSK, 32'h0);
        send(32'h01);
        repeat (200) @(posedge CLK);
        rd(`SDB_OFF_IST, 32'h1);
        chk(IRQ, 32'h0);
        xfer(1'b1, `SDB_OFF_IMSK, 32'h1);
        repeat (2) @(posedge CLK);
        chk(IRQ, 32'h1);
        xfer(1'b1, `SDB_OFF_IST, 32'h1);
        repeat (2) @(posedge CLK);
        chk(IRQ, 32'h0);
        // infrared widths at two cycles per sample tick
        xfer(1'b1, `SDB_OFF_BAUD, 32'h21);
        ir_low(2'h0, 6);
        ir_low(2'h1, 2);
        ir_low(2'h2, 2);
        ir_low(2'h3, 1);
        i_far.send_byte(8'h96, 32, 1'b1);
        repeat (32) @(posedge CLK);
        rd(`SDB_OFF_STAT1, 32'hE0);
        rd(`SDB_OFF_DATA, 32'h96);
        // a second reset leaves the buffer alone
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        rd(`SDB_OFF_DATA, 32'h96);
        rd(`SDB_OFF_IRC, 32'h0);
        complete_run;
    end
endmodule
`default_nettype wire
